// >>> logic/pcie_params.svh
// Register offsets, field positions, reset values and terminal numbers
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`ifndef PCIE_PARAMS_SVH
`define PCIE_PARAMS_SVH

`define PCIE_ADDR_W 12
`define PCIE_DATA_W 32

`define PCIE_OFF_CHG_FLAGS 12'h004
`define PCIE_OFF_CHG_EN 12'h005
`define PCIE_OFF_GLOBAL_CTRL 12'h01E
`define PCIE_OFF_FUNC_FLAG 12'h091
`define PCIE_OFF_SOCK_EVENT 12'h100
`define PCIE_OFF_SOCK_MASK 12'h104
`define PCIE_OFF_SIG_CFG 12'h108
`define PCIE_OFF_IRQ_STATUS 12'h10C
`define PCIE_OFF_IRQ_CLEAR 12'h110
`define PCIE_OFF_IRQ_ENABLE 12'h114

`define PCIE_GCTRL_CLR_MODE_BIT 2
`define PCIE_GCTRL_RESET 8'h00

`define PCIE_CHG_BAT1_BIT 0
`define PCIE_CHG_BAT2_BIT 1
`define PCIE_CHG_READY_BIT 2
`define PCIE_CHG_PWR_BIT 3
`define PCIE_SOCK_STS_BIT 0
`define PCIE_SOCK_DET_A_BIT 1
`define PCIE_SOCK_DET_B_BIT 2
`define PCIE_SOCK_PWR_BIT 3

`define PCIE_SIG_CFG_RESET 32'h0000_0001
`define PCIE_TERM_COUNT 7
`define PCIE_SERIAL_TERM 6

`endif

// >>> logic/pcie_pkg.sv
// Types shared by the card interrupt event block
package pcie_pkg;

  typedef enum logic [1:0] {
    PCIE_CARD_MEM16,
    PCIE_CARD_IO16,
    PCIE_CARD_CARDBUS,
    PCIE_CARD_SMART
  } pcie_card_t;

  typedef enum logic [1:0] {
    PCIE_LEGACY_NONE,
    PCIE_LEGACY_PARALLEL,
    PCIE_LEGACY_SERIAL
  } pcie_legacy_t;

  // Raw socket pins, all asynchronous to clk_i
  typedef struct packed {
    logic card_detect_b;
    logic card_detect_a;
    logic ready_int;
    logic battery_detect_two;
    logic battery_detect_one;
  } pcie_pins_t;

  // Software-held signalling configuration
  typedef struct packed {
    logic [2:0] func_term;
    logic [2:0] csc_term;
    pcie_card_t card_type;
    pcie_legacy_t legacy;
    logic pci_enable;
  } pcie_cfg_t;

  typedef struct packed {
    logic [6:0] drive;
    logic [6:0] enable;
  } pcie_term_t;

endpackage : pcie_pkg

// >>> logic/pcie_events.sv
// Card event detection, flags, masks and terminal signalling
`timescale 1ns/1ps
`default_nettype none
`include "pcie_params.svh"

module pcie_events #(
  parameter int ADDR_W = `PCIE_ADDR_W,
  parameter int DATA_W = `PCIE_DATA_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire pcie_pkg::pcie_pins_t pins_i,
  input wire logic power_cycle_done_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [DATA_W-1:0] rdata_o,
  output pcie_pkg::pcie_term_t term_o,
  output logic irq_o
);
  import pcie_pkg::*;

  localparam int NP = $bits(pcie_pins_t);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [NP-1:0] sync1_q, sync2_q, sync3_q, filt_q, filt_d;
  pcie_pins_t pin_now, pin_old;
  logic [3:0] settle_q;
  logic armed;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pins_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A bit moves only once the two later stages agree
  assign filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt_d;
    end
  end

  // Pin edge events stay muted until the reset zeros have left all three
  // stages and the filter; otherwise a card already seated with
  // high pins would look like a fresh edge after every reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_q <= 4'h0;
    end else begin
      settle_q <= {settle_q[2:0], 1'b1};
    end
  end

  assign armed = settle_q[3];

  assign pin_now = filt_d;
  assign pin_old = filt_q;

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  logic wr_chg_flags, wr_chg_en, wr_gctrl, wr_sock_ev, wr_sock_mask;
  logic wr_cfg, wr_irq_clr, wr_irq_en, rd_chg_flags;

  assign wr_chg_flags = write_i && hit(addr_i, `PCIE_OFF_CHG_FLAGS);
  assign wr_chg_en = write_i && hit(addr_i, `PCIE_OFF_CHG_EN);
  assign wr_gctrl = write_i && hit(addr_i, `PCIE_OFF_GLOBAL_CTRL);
  assign wr_sock_ev = write_i && hit(addr_i, `PCIE_OFF_SOCK_EVENT);
  assign wr_sock_mask = write_i && hit(addr_i, `PCIE_OFF_SOCK_MASK);
  assign wr_cfg = write_i && hit(addr_i, `PCIE_OFF_SIG_CFG);
  assign wr_irq_clr = write_i && hit(addr_i, `PCIE_OFF_IRQ_CLEAR);
  assign wr_irq_en = write_i && hit(addr_i, `PCIE_OFF_IRQ_ENABLE);
  assign rd_chg_flags = read_i && hit(addr_i, `PCIE_OFF_CHG_FLAGS);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] gctrl_q, chg_en_q;
  logic [3:0] sock_mask_q;
  pcie_cfg_t cfg_q;
  logic clr_on_write;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gctrl_q <= `PCIE_GCTRL_RESET;
      chg_en_q <= 8'h00;
      sock_mask_q <= 4'h0;
      cfg_q <= pcie_cfg_t'(`PCIE_SIG_CFG_RESET);
    end else begin
      if (wr_gctrl) begin
        gctrl_q <= wdata_i[7:0];
      end
      if (wr_chg_en) begin
        chg_en_q <= wdata_i[7:0];
      end
      if (wr_sock_mask) begin
        sock_mask_q <= wdata_i[3:0];
      end
      if (wr_cfg) begin
        cfg_q <= wdata_i[$bits(pcie_cfg_t)-1:0];
      end
    end
  end

  assign clr_on_write = gctrl_q[`PCIE_GCTRL_CLR_MODE_BIT];

  // ---------------------------------------------------------------
  // Event decode by card type
  // ---------------------------------------------------------------
  logic is_mem, is_io, is_cb, is_16;
  logic [3:0] chg_set, sock_set;
  logic func_level;

  assign is_mem = cfg_q.card_type == PCIE_CARD_MEM16;
  assign is_io = cfg_q.card_type == PCIE_CARD_IO16;
  assign is_cb = cfg_q.card_type == PCIE_CARD_CARDBUS;
  assign is_16 = is_mem || is_io;

  always_comb begin
    chg_set = 4'h0;
    sock_set = 4'h0;
    if (armed) begin
      if (is_mem) begin
        chg_set[`PCIE_CHG_BAT1_BIT] = pin_now.battery_detect_one
          ^ pin_old.battery_detect_one;
        chg_set[`PCIE_CHG_BAT2_BIT] = pin_now.battery_detect_two
          ^ pin_old.battery_detect_two;
        chg_set[`PCIE_CHG_READY_BIT] = pin_now.ready_int ^ pin_old.ready_int;
      end
      if (is_io) begin
        // Status change is active low on an I/O card
        chg_set[`PCIE_CHG_BAT1_BIT] = !pin_now.battery_detect_one
          && pin_old.battery_detect_one;
      end
      if (is_cb) begin
        sock_set[`PCIE_SOCK_STS_BIT] = pin_now.battery_detect_one
          && !pin_old.battery_detect_one;
      end
      sock_set[`PCIE_SOCK_DET_A_BIT] = pin_now.card_detect_a ^ pin_old.card_detect_a;
      sock_set[`PCIE_SOCK_DET_B_BIT] = pin_now.card_detect_b ^ pin_old.card_detect_b;
    end
    chg_set[`PCIE_CHG_PWR_BIT] = power_cycle_done_i && is_16;
    sock_set[`PCIE_SOCK_PWR_BIT] = power_cycle_done_i && is_cb;
  end

  // Request line is active low for both I/O and CardBus cards
  assign func_level = (is_io || is_cb) && !pin_old.ready_int;

  // ---------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------
  logic [3:0] chg_flags_q, sock_ev_q, chg_clr, sock_clr;
  logic func_flag_q;

  always_comb begin
    chg_clr = 4'h0;
    if (clr_on_write && wr_chg_flags) begin
      chg_clr = wdata_i[3:0];
    end else if (!clr_on_write && rd_chg_flags) begin
      chg_clr = 4'hF;
    end
  end

  assign sock_clr = wr_sock_ev ? wdata_i[3:0] : 4'h0;

  // New events win over a clear in the same cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chg_flags_q <= 4'h0;
      sock_ev_q <= 4'h0;
      func_flag_q <= 1'b0;
    end else begin
      chg_flags_q <= (chg_flags_q & ~chg_clr) | chg_set;
      sock_ev_q <= (sock_ev_q & ~sock_clr) | sock_set;
      func_flag_q <= func_level;
    end
  end

  logic csc_req, func_req;
  assign csc_req = |(chg_flags_q & chg_en_q[3:0]) | |(sock_ev_q & sock_mask_q);
  assign func_req = func_flag_q;

  // ---------------------------------------------------------------
  // Summary interrupt
  // ---------------------------------------------------------------
  logic [2:0] irq_sts_q, irq_en_q, irq_set;
  logic func_old_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      func_old_q <= 1'b0;
    end else begin
      func_old_q <= func_flag_q;
    end
  end

  assign irq_set = {func_flag_q && !func_old_q, |sock_set, |chg_set};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_sts_q <= 3'h0;
      irq_en_q <= 3'h0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~(wr_irq_clr ? wdata_i[2:0] : 3'h0)) | irq_set;
      if (wr_irq_en) begin
        irq_en_q <= wdata_i[2:0];
      end
    end
  end

  assign irq_o = |(irq_sts_q & irq_en_q);

  // ---------------------------------------------------------------
  // Multifunction terminals
  // ---------------------------------------------------------------
  // Terminal 0 is the open-drain PCI line; legacy requests go to
  // the terminals software picks, serial uses one fixed terminal.
  pcie_term_t term_d;

  always_comb begin
    term_d.drive = 7'h00;
    term_d.enable = 7'h00;
    if (cfg_q.pci_enable) begin
      term_d.enable[0] = csc_req || func_req;
    end
    case (cfg_q.legacy)
      PCIE_LEGACY_PARALLEL: begin
        if (cfg_q.csc_term != 3'd0) begin
          term_d.enable[cfg_q.csc_term] = 1'b1;
          term_d.drive[cfg_q.csc_term] = csc_req;
        end
        if (cfg_q.func_term != 3'd0) begin
          term_d.enable[cfg_q.func_term] = 1'b1;
          term_d.drive[cfg_q.func_term] = term_d.drive[cfg_q.func_term] | func_req;
        end
      end
      PCIE_LEGACY_SERIAL: begin
        // Framing is outside this block; the line is pulled low
        // while any request is pending
        term_d.enable[`PCIE_SERIAL_TERM] = csc_req || func_req;
        term_d.drive[`PCIE_SERIAL_TERM] = 1'b0;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      term_o <= '0;
    end else begin
      term_o <= term_d;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (hit(addr_i, `PCIE_OFF_CHG_FLAGS)) begin
      rdata_d[3:0] = chg_flags_q;
    end else if (hit(addr_i, `PCIE_OFF_CHG_EN)) begin
      rdata_d[7:0] = chg_en_q;
    end else if (hit(addr_i, `PCIE_OFF_GLOBAL_CTRL)) begin
      rdata_d[7:0] = gctrl_q;
    end else if (hit(addr_i, `PCIE_OFF_FUNC_FLAG)) begin
      rdata_d[0] = func_flag_q;
    end else if (hit(addr_i, `PCIE_OFF_SOCK_EVENT)) begin
      rdata_d[3:0] = sock_ev_q;
    end else if (hit(addr_i, `PCIE_OFF_SOCK_MASK)) begin
      rdata_d[3:0] = sock_mask_q;
    end else if (hit(addr_i, `PCIE_OFF_SIG_CFG)) begin
      rdata_d[$bits(pcie_cfg_t)-1:0] = cfg_q;
    end else if (hit(addr_i, `PCIE_OFF_IRQ_STATUS)) begin
      rdata_d[2:0] = irq_sts_q;
    end else if (hit(addr_i, `PCIE_OFF_IRQ_ENABLE)) begin
      rdata_d[2:0] = irq_en_q;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (read_i) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= '0;
    end
  end

endmodule : pcie_events
`default_nettype wire

// >>> dv/pcie_card_model.sv
// Inserted card model driving the raw socket pins
`timescale 1ns/1ps
`default_nettype none
module pcie_card_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] toggle_i,
  output pcie_pkg::pcie_pins_t pins_o
);
  import pcie_pkg::*;
  // Card seated: detects low, request and battery lines idle high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pins_o <= pcie_pins_t'(5'h07);
    end else begin
      pins_o <= pins_o ^ toggle_i;
    end
  end
endmodule : pcie_card_model
`default_nettype wire

// >>> dv/pcie_events_sva.sv
// Port checker for the card interrupt event block
`timescale 1ns/1ps
`default_nettype none
`include "pcie_params.svh"
module pcie_events_sva #(
  parameter int ADDR_W = `PCIE_ADDR_W,
  parameter int DATA_W = `PCIE_DATA_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire pcie_pkg::pcie_pins_t pins_i,
  input wire logic power_cycle_done_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire pcie_pkg::pcie_term_t term_o,
  input wire logic irq_o
);
  import pcie_pkg::*;
  pcie_pins_t pins_q;
  logic [2:0] still_q;
  logic mode_q;
  logic quiet;
  // Quiet only once the pin synchroniser has surely settled
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pins_q <= '0;
      still_q <= 3'h0;
    end else begin
      pins_q <= pins_i;
      still_q <= (pins_i != pins_q) ? 3'h0 : (still_q == 3'h7 ? 3'h7 : still_q + 3'h1);
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= 1'b0;
    end else if (write_i && addr_i == `PCIE_OFF_GLOBAL_CTRL) begin
      mode_q <= wdata_i[`PCIE_GCTRL_CLR_MODE_BIT];
    end
  end
  assign quiet = (still_q == 3'h7) && !power_cycle_done_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_rd_chg;
    read_i && addr_i == `PCIE_OFF_CHG_FLAGS && quiet && !mode_q;
  endsequence
  sequence s_clr_sock;
    write_i && addr_i == `PCIE_OFF_SOCK_EVENT && wdata_i[3:0] == 4'hF && quiet;
  endsequence
  sequence s_wr_en;
    write_i && addr_i == `PCIE_OFF_CHG_EN;
  endsequence
  a_rdata_idle: assert property (!read_i |=> rdata_o == '0)
    else $error("read data not zero outside read answer");
  a_unmapped_rd: assert property (read_i && addr_i[ADDR_W-1:9] != '0 |=> rdata_o == '0)
    else $error("unmapped read returned data");
  a_narrow_rd: assert property (read_i && addr_i == `PCIE_OFF_CHG_FLAGS |=> rdata_o[DATA_W-1:4] == '0)
    else $error("change flags upper bits not zero");
  a_cor_clear: assert property (s_rd_chg ##1 s_rd_chg |=> rdata_o[3:0] == 4'h0)
    else $error("change flags survived clear on read");
  a_sock_w1c: assert property (s_clr_sock ##1 read_i && addr_i == `PCIE_OFF_SOCK_EVENT |=> rdata_o[3:0] == 4'h0)
    else $error("socket events survived write one clear");
  a_en_rdback: assert property (s_wr_en ##1 read_i && addr_i == `PCIE_OFF_CHG_EN |=> rdata_o[7:0] == $past(wdata_i[7:0], 2))
    else $error("change enables read back wrong");
  a_irq_masked: assert property (write_i && addr_i == `PCIE_OFF_IRQ_ENABLE && wdata_i == '0 |=> !irq_o)
    else $error("interrupt high with all enables off");
  a_irq_clear: assert property (write_i && addr_i == `PCIE_OFF_IRQ_CLEAR && wdata_i[2:0] == 3'h7 && quiet |=> !irq_o)
    else $error("interrupt high after full status clear");
endmodule : pcie_events_sva
bind pcie_events pcie_events_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_sva (.clk_i(clk_i),
  .reset_n_i(reset_n_i), .pins_i(pins_i), .power_cycle_done_i(power_cycle_done_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
  .term_o(term_o), .irq_o(irq_o));
`default_nettype wire

// >>> dv/pcie_events_tb.sv
// Self-checking bench for the card interrupt event block
`timescale 1ns/1ps
`default_nettype none
`include "pcie_params.svh"
module pcie_events_tb;
  import pcie_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic pwr = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [4:0] tgl = 5'h00;
  logic [31:0] rdata;
  logic [31:0] rnd;
  logic irq;
  logic [75:0] note;
  logic [75:0] note_q[$];
  pcie_pins_t pins;
  pcie_term_t term;
  int n_errors = 0;
  int checks_done = 0;
  int unsigned d;
  always #12.5 clk_i = ~clk_i;
  pcie_events i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .pins_i(pins),
    .power_cycle_done_i(pwr), .addr_i(addr), .wdata_i(wdata), .write_i(wr), .read_i(rd),
    .rdata_o(rdata), .term_o(term), .irq_o(irq));
  pcie_card_model i_card (.clk_i(clk_i), .reset_n_i(reset_n_i), .toggle_i(tgl), .pins_o(pins));
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
  endtask : bus
  task automatic wreg(input logic [11:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask : wreg
  task automatic rreg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    note_q.push_back({a, m, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask : rreg
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask : idle
  task automatic tog(input logic [4:0] m);
    idle(1);
    tgl <= m;
    @(posedge clk_i);
    tgl <= 5'h00;
    idle(8);
  endtask : tog
  task automatic pulse;
    idle(1);
    pwr <= 1'b1;
    @(posedge clk_i);
    pwr <= 1'b0;
    idle(3);
  endtask : pulse
  task automatic cfg(input pcie_card_t c);
    wreg(`PCIE_OFF_SIG_CFG, {27'h0, c, 2'h1, 1'b1});
  endtask : cfg
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    checks_done++;
    if ((rdata & m) !== e) begin
      n_errors++;
      $display("MISMATCH rdata at %h expected %h seen %h", a, e, rdata & m);
    end
  endtask : chk_rd
  task automatic chk_irq(input logic e);
    @(negedge clk_i);
    checks_done++;
    if (irq !== e) begin
      n_errors++;
      $display("MISMATCH irq_o expected %b seen %b", e, irq);
    end
  endtask : chk_irq
  task automatic chk_term(input logic [13:0] e);
    @(negedge clk_i);
    checks_done++;
    if (term !== e) begin
      n_errors++;
      $display("MISMATCH term_o expected %h seen %h", e, term);
    end
  endtask : chk_term
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk_i) rd_q <= rd;
  always @(negedge clk_i) begin
    if (rd_q) begin
      note = note_q.pop_front();
      chk_rd(note[75:64], note[63:32], note[31:0]);
    end
  end
  // Whole run is a few hundred cycles; allow a wide margin
  initial begin
    #500000;
    n_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(89251));
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rreg(`PCIE_OFF_SIG_CFG, ALL, `PCIE_SIG_CFG_RESET);
    rreg(`PCIE_OFF_GLOBAL_CTRL, ALL, {24'h0, `PCIE_GCTRL_RESET});
    rreg(`PCIE_OFF_SOCK_MASK, ALL, 32'h0000_0000);
    rnd = $urandom;
    wreg(`PCIE_OFF_CHG_EN, rnd);
    rreg(`PCIE_OFF_CHG_EN, ALL, {24'h0, rnd[7:0]});
    wreg(12'h2FF, rnd);
    rreg(12'h2FF, ALL, 32'h0000_0000);
    idle(1);
    chk_irq(1'b0);
    rreg(`PCIE_OFF_CHG_FLAGS, 32'hF, 32'h0);
    rreg(`PCIE_OFF_IRQ_STATUS, 32'h7, 32'h0);
    $display("test reset done");
    tog(5'h07);
    tog(5'h03);
    rreg(`PCIE_OFF_CHG_FLAGS, 32'hF, 32'h7);
    rreg(`PCIE_OFF_CHG_FLAGS, 32'hF, 32'h0);
    rreg(`PCIE_OFF_FUNC_FLAG, 32'h1, 32'h0);
    tog(5'h04);
    rreg(`PCIE_OFF_CHG_FLAGS, 32'hF, 32'h4);
    pulse();
    wreg(`PCIE_OFF_GLOBAL_CTRL, 32'h4);
    rreg(`PCIE_OFF_CHG_FLAGS, 32'hF, 32'h8);
    rreg(`PCIE_OFF_CHG_FLAGS, 32'hF, 32'h8);
    wreg(`PCIE_OFF_CHG_FLAGS, 32'h8);
    rreg(`PCIE_OFF_CHG_FLAGS, 32'hF, 32'h0);
    wreg(`PCIE_OFF_GLOBAL_CTRL, 32'h0);
    $display("test memory card done");
    wreg(`PCIE_OFF_IRQ_CLEAR, 32'h7);
    wreg(`PCIE_OFF_IRQ_ENABLE, 32'h1);
    idle(1);
    chk_irq(1'b0);
    pulse();
    chk_irq(1'b1);
    rreg(`PCIE_OFF_IRQ_STATUS, 32'h1, 32'h1);
    wreg(`PCIE_OFF_IRQ_ENABLE, 32'h0);
    idle(1);
    chk_irq(1'b0);
    wreg(`PCIE_OFF_IRQ_ENABLE, 32'h1);
    idle(1);
    chk_irq(1'b1);
    wreg(`PCIE_OFF_IRQ_CLEAR, 32'h7);
    idle(1);
    chk_irq(1'b0);
    rreg(`PCIE_OFF_CHG_FLAGS, 32'hF, 32'h8);
    $display("test interrupt done");
    cfg(PCIE_CARD_IO16);
    tog(5'h01);
    rreg(`PCIE_OFF_CHG_FLAGS, 32'hF, 32'h1);
    tog(5'h04);
    rreg(`PCIE_OFF_FUNC_FLAG, 32'h1, 32'h1);
    tog(5'h04);
    rreg(`PCIE_OFF_FUNC_FLAG, 32'h1, 32'h0);
    $display("test io card done");
    wreg(`PCIE_OFF_SIG_CFG, {21'h0, 3'h0, 3'h1, PCIE_CARD_CARDBUS, 2'h1, 1'b1});
    tog(5'h01);
    rreg(`PCIE_OFF_SOCK_EVENT, 32'hF, 32'h1);
    tog(5'h04);
    rreg(`PCIE_OFF_FUNC_FLAG, 32'h1, 32'h1);
    tog(5'h04);
    pulse();
    rreg(`PCIE_OFF_SOCK_EVENT, 32'hF, 32'h9);
    wreg(`PCIE_OFF_SOCK_MASK, 32'h8);
    idle(2);
    chk_term(14'h0103);
    wreg(`PCIE_OFF_SOCK_EVENT, 32'hF);
    rreg(`PCIE_OFF_SOCK_EVENT, 32'hF, 32'h0);
    idle(2);
    chk_term(14'h0002);
    for (int i = 0; i < 4; i++) begin
      d = $urandom % 2;
      tog(5'h08 << d);
      rreg(`PCIE_OFF_SOCK_EVENT, 32'hF, 32'h2 << d);
      wreg(`PCIE_OFF_SOCK_EVENT, 32'hF);
    end
    $display("test cardbus done");
    idle(3);
    end_sim();
  end
endmodule : pcie_events_tb
`default_nettype wire
